// >>> bus_evt_if.sv
`timescale 1ns/10ps
interface bus_evt_if;
  logic scl_rise; // sampled scl went high
  logic scl_fall; // sampled scl went low
  logic sda_lvl; // sampled data line level
  logic start_evt; // start or repeated start
  logic stop_evt; // stop condition
  logic addr_hi_lvl; // synchronised select pin
  logic addr_lo_lvl;
  modport front (output scl_rise, scl_fall, sda_lvl, start_evt, stop_evt, addr_hi_lvl, addr_lo_lvl);
  modport core (input scl_rise, scl_fall, sda_lvl, start_evt, stop_evt, addr_hi_lvl, addr_lo_lvl);
endinterface

// >>> dac_i2c_pkg.sv
package dac_i2c_pkg;
  // fixed upper address bits and the broadcast byte
  localparam logic [4:0] OWN_ADDR_TOP = 5'h13;
  localparam logic [7:0] BCAST_ADDR = 8'h90;
  // high-speed master code, upper five bits of the byte
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam int CHANS = 4;
  localparam int WORD_W = 12;
  // control byte fields
  localparam int CTRL_MODE_HI = 5;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_SEL_HI = 2;
  localparam int CTRL_SEL_LO = 1;
  localparam int CTRL_PD = 0;
  // power-down code in the high byte, data bits in the low byte
  localparam int HI_PD_HI = 7;
  localparam int HI_PD_LO = 6;
  localparam int LO_D1 = 7;
  localparam int LO_D0 = 6;
  // load modes
  localparam logic [1:0] LOAD_TEMP = 2'h0;
  localparam logic [1:0] LOAD_SINGLE = 2'h1;
  localparam logic [1:0] LOAD_ALL = 2'h2;
  localparam logic [1:0] LOAD_BCAST = 2'h3;
  // reset values
  localparam logic [11:0] WORD_RST = 12'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // bits per byte, and clocks after reset before the strap is caught
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // gray order along idle, addr, ctrl, hi, lo
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_ADDR = 3'h1,
    PH_CTRL = 3'h3,
    PH_HI = 3'h2,
    PH_LO = 3'h6,
    PH_SKIP = 3'h7
  } phase_type;

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic prev_scl;
    logic prev_sda;
  } front_state_type;

  typedef struct packed {
    phase_type phase;
    logic in_ack;
    logic ack_drive;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ctrl;
    logic [7:0] hi;
    logic [7:0] lo;
    logic hs_mode;
    logic addr_taken;
    logic [1:0] strap_cnt;
    logic [1:0] addr_bits;
    logic [CHANS-1:0][WORD_W-1:0] hold;
    logic [CHANS-1:0][WORD_W-1:0] outs;
  } core_state_type;
endpackage

// >>> i2c_master_model.sv
`timescale 1ns/10ps
// two-wire bus master on the far side; pins change only after clk falls
module i2c_master_model (
  input wire logic clk,
  input wire logic sda_line, // resolved wire level, pulled up when nobody pulls
  output logic scl,
  output logic sda_m // 0 pulls the data line low, 1 releases it
);
  // idle bus: both lines high, the link clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // half of the 200 ns link period is 4 clk cycles
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // start or repeated start; restarts keep the high-speed mode alive
  task automatic start_c();
    wt(1);
    sda_m = 1'b1;
    wt(3);
    scl = 1'b1;
    wt(4);
    sda_m = 1'b0;
    wt(4);
    scl = 1'b0;
  endtask
  // stop: data rises while the clock is high
  task automatic stop_c();
    wt(1);
    sda_m = 1'b0;
    wt(3);
    scl = 1'b1;
    wt(4);
    sda_m = 1'b1;
    wt(4);
  endtask
  // one byte msb first, then a ninth clock with the line released
  // the master code goes out at this same slow rate right after a start
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      wt(1);
      sda_m = b[i];
      wt(3);
      scl = 1'b1;
      wt(4);
      scl = 1'b0;
    end
    wt(1);
    sda_m = 1'b1;
    wt(3);
    scl = 1'b1;
    wt(3);
    ack = ~sda_line; // acknowledge is the line held low mid-high phase
    wt(1);
    scl = 1'b0;
  endtask
endmodule // i2c_master_model

// >>> pin_front_end.sv
`timescale 1ns/10ps
module pin_front_end (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_in,
  input wire logic addr_pin_hi,
  input wire logic addr_pin_lo,
  bus_evt_if.front ev
);
  dac_i2c_pkg::front_state_type r_r;
  dac_i2c_pkg::front_state_type r_nxt;

  // two flops per pin; the second stage, and a delayed copy of it for the bus lines, is looked at
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.meta = {scl_pin, sda_in, addr_pin_hi, addr_pin_lo};
    r_nxt.sync = r_r.meta;
    r_nxt.prev_scl = r_r.sync[3];
    r_nxt.prev_sda = r_r.sync[2];
  end

  // idle bus reads high, so reset to ones to avoid a false start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r_r <= '{meta: 4'hf, sync: 4'hf, prev_scl: 1'b1, prev_sda: 1'b1};
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // edges are one-cycle pulses; hs clock high phase spans several cycles
  assign ev.scl_rise = r_r.sync[3] & ~r_r.prev_scl;
  assign ev.scl_fall = ~r_r.sync[3] & r_r.prev_scl;
  assign ev.sda_lvl = r_r.sync[2];
  assign ev.start_evt = r_r.sync[3] & r_r.prev_scl & r_r.prev_sda & ~r_r.sync[2];
  assign ev.stop_evt = r_r.sync[3] & r_r.prev_scl & ~r_r.prev_sda & r_r.sync[2];
  assign ev.addr_hi_lvl = r_r.sync[1];
  assign ev.addr_lo_lvl = r_r.sync[0];
endmodule // pin_front_end

// >>> quad_dac_i2c_write_decoder.sv
// Contract
// - never acknowledge hs code, enter hs mode
// - restart continues hs, stop returns to f/s
// - acknowledge every accepted byte on ninth clock
// - update on low-byte acknowledge falling edge
// - control byte persists for further updates
// - back-to-back high/low pairs accepted
// - after stop ignore until start plus match
// - own address 10011, select pins, direction
// - select pins caught once after power-up
// - broadcast 0x90 accepted, writes only
// - control byte field layout
// - mode 00 loads holding register only
// - mode 01 loads holding and output
// - mode 10 also loads others from holding
// - mode 11 select low: all from holding
// - mode 11 select high: all take word
// - flag set: high byte carries pd code
// - high byte bits 9:2, low 1:0
// - twelve-bit registers, pd code on top
// - power-on reset clears all storage
`timescale 1ns/10ps
module quad_dac_i2c_write_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_pin_hi,
  input wire logic addr_pin_lo,
  output logic hs_mode,
  output logic [3:0][11:0] output_words,
  output logic [3:0][11:0] holding_words
);
  dac_i2c_pkg::core_state_type r_r;
  dac_i2c_pkg::core_state_type r_nxt;
  // update strobe and the word it carries
  logic upd;
  logic [11:0] word;
  logic [1:0] load_mode;
  logic [1:0] chan_sel;
  logic [7:0] own_addr;

  bus_evt_if ev ();

  pin_front_end front (
    .clk(clk),
    .rst(rst),
    .scl_pin(scl_pin),
    .sda_in(sda_in),
    .addr_pin_hi(addr_pin_hi),
    .addr_pin_lo(addr_pin_lo),
    .ev(ev)
  );

  // control fields stay in force until a new control byte
  assign load_mode = {r_r.ctrl[dac_i2c_pkg::CTRL_MODE_HI], r_r.ctrl[dac_i2c_pkg::CTRL_MODE_LO]};
  assign chan_sel = {r_r.ctrl[dac_i2c_pkg::CTRL_SEL_HI], r_r.ctrl[dac_i2c_pkg::CTRL_SEL_LO]};
  assign own_addr = {dac_i2c_pkg::OWN_ADDR_TOP, r_r.addr_bits, 1'b0};

  // word built from the stored bytes: pd code on top, data below
  always_comb
  begin
    if (r_r.ctrl[dac_i2c_pkg::CTRL_PD])
    begin
      word = {r_r.hi[dac_i2c_pkg::HI_PD_HI], r_r.hi[dac_i2c_pkg::HI_PD_LO], 10'h000};
    end
    else
    begin
      word = {2'h0, r_r.hi, r_r.lo[dac_i2c_pkg::LO_D1], r_r.lo[dac_i2c_pkg::LO_D0]};
    end
  end

  // serial protocol and register update
  always_comb
  begin
    r_nxt = r_r;
    upd = 1'b0;
    // catch the select pins once, after the synchroniser has filled
    if (!r_r.addr_taken)
    begin
      if (r_r.strap_cnt == dac_i2c_pkg::STRAP_WAIT)
      begin
        r_nxt.addr_bits = {ev.addr_hi_lvl, ev.addr_lo_lvl};
        r_nxt.addr_taken = 1'b1;
      end
      else
      begin
        r_nxt.strap_cnt = r_r.strap_cnt + 2'h1;
      end
    end
    if (ev.stop_evt)
    begin
      // stop: release, go idle, back to f/s settings
      r_nxt.phase = dac_i2c_pkg::PH_IDLE;
      r_nxt.in_ack = 1'b0;
      r_nxt.ack_drive = 1'b0;
      r_nxt.bit_cnt = 4'h0;
      r_nxt.hs_mode = 1'b0;
    end
    else if (ev.start_evt)
    begin
      // start or repeated start: hs mode survives a restart
      r_nxt.phase = dac_i2c_pkg::PH_ADDR;
      r_nxt.in_ack = 1'b0;
      r_nxt.ack_drive = 1'b0;
      r_nxt.bit_cnt = 4'h0;
    end
    else if (ev.scl_rise && r_r.phase != dac_i2c_pkg::PH_IDLE && !r_r.in_ack && r_r.bit_cnt < dac_i2c_pkg::BYTE_BITS)
    begin
      // data is taken on the rising clock, msb first
      r_nxt.shift = {r_r.shift[6:0], ev.sda_lvl};
      r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
    end
    else if (ev.scl_fall && r_r.phase != dac_i2c_pkg::PH_IDLE)
    begin
      if (r_r.in_ack)
      begin
        // end of the ninth clock: release the line and move on
        r_nxt.in_ack = 1'b0;
        r_nxt.ack_drive = 1'b0;
        r_nxt.bit_cnt = 4'h0;
        // the phase only advances here, so the high byte's acknowledge
        // can never be taken for the one that follows the low byte
        case (r_r.phase)
          dac_i2c_pkg::PH_ADDR:
          begin
            // an address left unacknowledged sends the rest of the frame to skip
            if (r_r.ack_drive)
            begin
              r_nxt.phase = dac_i2c_pkg::PH_CTRL;
            end
            else
            begin
              r_nxt.phase = dac_i2c_pkg::PH_SKIP;
            end
          end
          dac_i2c_pkg::PH_CTRL:
          begin
            r_nxt.phase = dac_i2c_pkg::PH_HI;
          end
          dac_i2c_pkg::PH_HI:
          begin
            r_nxt.phase = dac_i2c_pkg::PH_LO;
          end
          dac_i2c_pkg::PH_LO:
          begin
            upd = 1'b1;
            r_nxt.phase = dac_i2c_pkg::PH_HI;
          end
          default:
          begin
            r_nxt.phase = r_r.phase;
          end
        endcase
      end
      else if (r_r.bit_cnt == dac_i2c_pkg::BYTE_BITS)
      begin
        // full byte seen: decide the acknowledge for the ninth clock
        r_nxt.in_ack = 1'b1;
        case (r_r.phase)
          dac_i2c_pkg::PH_ADDR:
          begin
            if (r_r.shift[7:3] == dac_i2c_pkg::HS_CODE_TOP)
            begin
              // master code: switch speed, never acknowledge
              r_nxt.hs_mode = 1'b1;
              r_nxt.ack_drive = 1'b0;
            end
            else if (r_r.shift == own_addr || r_r.shift == dac_i2c_pkg::BCAST_ADDR)
            begin
              // write to own address or broadcast; reads are not served
              r_nxt.ack_drive = 1'b1;
            end
            else
            begin
              r_nxt.ack_drive = 1'b0;
            end
          end
          dac_i2c_pkg::PH_CTRL:
          begin
            r_nxt.ctrl = r_r.shift;
            r_nxt.ack_drive = 1'b1;
          end
          dac_i2c_pkg::PH_HI:
          begin
            // high byte alone changes no channel
            r_nxt.hi = r_r.shift;
            r_nxt.ack_drive = 1'b1;
          end
          dac_i2c_pkg::PH_LO:
          begin
            r_nxt.lo = r_r.shift;
            r_nxt.ack_drive = 1'b1;
          end
          default:
          begin
            r_nxt.ack_drive = 1'b0;
          end
        endcase
      end
    end
    // apply the update as the low-byte acknowledge ends
    if (upd)
    begin
      for (int c = 0; c < dac_i2c_pkg::CHANS; c++)
      begin
        case (load_mode)
          dac_i2c_pkg::LOAD_TEMP:
          begin
            if (chan_sel == c[1:0])
            begin
              r_nxt.hold[c] = word;
            end
          end
          dac_i2c_pkg::LOAD_SINGLE:
          begin
            if (chan_sel == c[1:0])
            begin
              r_nxt.hold[c] = word;
              r_nxt.outs[c] = word;
            end
          end
          dac_i2c_pkg::LOAD_ALL:
          begin
            if (chan_sel == c[1:0])
            begin
              r_nxt.hold[c] = word;
              r_nxt.outs[c] = word;
            end
            else
            begin
              r_nxt.outs[c] = r_r.hold[c];
            end
          end
          default:
          begin
            // broadcast mode uses only the high select bit, not the channel number
            if (r_r.ctrl[dac_i2c_pkg::CTRL_SEL_HI])
            begin
              r_nxt.hold[c] = word;
              r_nxt.outs[c] = word;
            end
            else
            begin
              r_nxt.outs[c] = r_r.hold[c];
            end
          end
        endcase
      end
    end
  end

  // state register; all storage powers up at zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r_r <= '{phase: dac_i2c_pkg::PH_IDLE, in_ack: 1'b0, ack_drive: 1'b0, bit_cnt: 4'h0,
               shift: dac_i2c_pkg::BYTE_RST, ctrl: dac_i2c_pkg::BYTE_RST, hi: dac_i2c_pkg::BYTE_RST,
               lo: dac_i2c_pkg::BYTE_RST, hs_mode: 1'b0, addr_taken: 1'b0, strap_cnt: 2'h0,
               addr_bits: 2'h0, hold: {4{dac_i2c_pkg::WORD_RST}},
               outs: {4{dac_i2c_pkg::WORD_RST}}};
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~r_r.ack_drive;
  assign hs_mode = r_r.hs_mode;
  assign output_words = r_r.outs;
  assign holding_words = r_r.hold;

  AST_HS_NO_ACK: assert property (@(posedge clk) disable iff (rst)
    $rose(r_r.hs_mode) |-> sda_oe_n [*2])
    else $error("master code was acknowledged");

  AST_STOP_FS: assert property (@(posedge clk) disable iff (rst)
    ev.stop_evt |=> (!r_r.hs_mode && sda_oe_n && r_r.phase == dac_i2c_pkg::PH_IDLE))
    else $error("stop did not return to idle f/s mode");

  AST_ACK_RELEASE: assert property (@(posedge clk) disable iff (rst)
    $rose(sda_oe_n) |-> $past(ev.scl_fall || ev.stop_evt || ev.start_evt))
    else $error("acknowledge released outside a clock fall");

  AST_UPD_MOMENT: assert property (@(posedge clk) disable iff (rst)
    (r_r.outs != $past(r_r.outs)) |-> $past(ev.scl_fall && r_r.in_ack && r_r.phase == dac_i2c_pkg::PH_LO))
    else $error("output changed away from the low-byte acknowledge");

  AST_MODE0_HOLD: assert property (@(posedge clk) disable iff (rst)
    (upd && load_mode == dac_i2c_pkg::LOAD_TEMP) |=> ($stable(r_r.outs) && r_r.hold[$past(chan_sel)] == $past(word)))
    else $error("mode 00 touched an output register");

  AST_MODE1_LOAD: assert property (@(posedge clk) disable iff (rst)
    (upd && load_mode == dac_i2c_pkg::LOAD_SINGLE) |=> (r_r.outs[$past(chan_sel)] == $past(word)))
    else $error("mode 01 did not load the output register");

  AST_STRAP_FROZEN: assert property (@(posedge clk) disable iff (rst)
    r_r.addr_taken |=> $stable(r_r.addr_bits))
    else $error("address bits changed after power-up");

  AST_FOREIGN_QUIET: assert property (@(posedge clk) disable iff (rst)
    (r_r.phase == dac_i2c_pkg::PH_SKIP || r_r.phase == dac_i2c_pkg::PH_IDLE) |-> sda_oe_n)
    else $error("data line driven while not addressed");

  // acknowledge, update moment, load modes, restart and address behaviour
  AST_ACK_STANDS: assert property (@(posedge clk) disable iff (rst)
    (!sda_oe_n && !ev.scl_fall && !ev.stop_evt && !ev.start_evt) |=> !sda_oe_n)
    else $error("acknowledge dropped inside the ninth clock");

  AST_HI_ACK_QUIET: assert property (@(posedge clk) disable iff (rst)
    (ev.scl_fall && r_r.in_ack && r_r.phase == dac_i2c_pkg::PH_HI) |=>
      ($stable(r_r.outs) && $stable(r_r.hold)))
    else $error("high byte acknowledge changed a channel");

  AST_MODE2_SYNC: assert property (@(posedge clk) disable iff (rst)
    (upd && load_mode == dac_i2c_pkg::LOAD_ALL) |=>
      (r_r.outs[$past(chan_sel)] == $past(word) && r_r.hold[$past(chan_sel)] == $past(word)))
    else $error("mode 10 did not load the selected channel");

  AST_BCAST_COPY: assert property (@(posedge clk) disable iff (rst)
    (upd && load_mode == dac_i2c_pkg::LOAD_BCAST && !r_r.ctrl[dac_i2c_pkg::CTRL_SEL_HI]) |=>
      (r_r.outs == $past(r_r.hold) && $stable(r_r.hold)))
    else $error("broadcast copy did not load outputs from holding");

  AST_BCAST_WORD: assert property (@(posedge clk) disable iff (rst)
    (upd && load_mode == dac_i2c_pkg::LOAD_BCAST && r_r.ctrl[dac_i2c_pkg::CTRL_SEL_HI]) |=>
      (r_r.outs == {4{$past(word)}} && r_r.hold == {4{$past(word)}}))
    else $error("broadcast word did not reach every channel");

  AST_HS_KEPT: assert property (@(posedge clk) disable iff (rst)
    (ev.start_evt && r_r.hs_mode) |=> r_r.hs_mode)
    else $error("repeated start left high-speed mode");

  AST_READ_REFUSED: assert property (@(posedge clk) disable iff (rst)
    (ev.scl_fall && !r_r.in_ack && r_r.phase == dac_i2c_pkg::PH_ADDR && r_r.bit_cnt == dac_i2c_pkg::BYTE_BITS &&
      r_r.shift[0]) |=> sda_oe_n)
    else $error("read address was acknowledged");

  AST_MATCH_ACK: assert property (@(posedge clk) disable iff (rst)
    (ev.scl_fall && !r_r.in_ack && r_r.phase == dac_i2c_pkg::PH_ADDR && r_r.bit_cnt == dac_i2c_pkg::BYTE_BITS &&
      (r_r.shift == {dac_i2c_pkg::OWN_ADDR_TOP, r_r.addr_bits, 1'b0} || r_r.shift == dac_i2c_pkg::BCAST_ADDR)) |=>
      !sda_oe_n)
    else $error("matching write address not acknowledged");

  AST_IDLE_DEAF: assert property (@(posedge clk) disable iff (rst)
    (r_r.phase == dac_i2c_pkg::PH_IDLE && !ev.start_evt) |=>
      (r_r.phase == dac_i2c_pkg::PH_IDLE && $stable(r_r.outs) && $stable(r_r.hold)))
    else $error("traffic after stop was not ignored");
endmodule // quad_dac_i2c_write_decoder

// >>> quad_dac_i2c_write_decoder_tb_top.sv
`timescale 1ns/10ps
module quad_dac_i2c_write_decoder_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sda_m;
  logic sda_line;
  logic sda_out;
  logic sda_oe_n;
  logic addr_pin_hi = 1'b1; // strap 10: own address byte 9c
  logic addr_pin_lo = 1'b0;
  logic hs_mode;
  logic [3:0][11:0] output_words;
  logic [3:0][11:0] holding_words;
  logic [3:0][11:0] eo = '0; // expected output words
  logic [3:0][11:0] eh = '0; // expected holding words
  logic ack;
  int bad_count = 0;
  int total_checks = 0;
  // open drain wire with pull-up: low if either side pulls
  assign sda_line = sda_m & (sda_oe_n | sda_out);
  always #12.5 clk = ~clk;
  i2c_master_model u_i2c_master_model (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
  quad_dac_i2c_write_decoder u_quad_dac_i2c_write_decoder (.clk(clk), .rst(rst), .scl_pin(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_pin_hi(addr_pin_hi),
    .addr_pin_lo(addr_pin_lo), .hs_mode(hs_mode), .output_words(output_words), .holding_words(holding_words));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // all eight words against the expectation
  task automatic chk_all();
    for (int i = 0; i < 4; i++)
    begin
      chk_word(output_words[i], eo[i]);
      chk_word(holding_words[i], eh[i]);
    end
  endtask
  // expected effect of one completed high/low pair
  task automatic upd(input logic [7:0] c, input logic [7:0] hi, input logic [7:0] lo);
    logic [11:0] w;
    logic [1:0] s;
    w = c[0] ? {hi[7:6], 10'h000} : {hi, lo[7:6]};
    s = c[2:1];
    case (c[5:4])
      2'h0:
      begin
        eh[s] = w;
      end
      2'h1:
      begin
        eh[s] = w;
        eo[s] = w;
      end
      2'h2:
      begin
        eo = eh;
        eh[s] = w;
        eo[s] = w;
      end
      default:
      begin
        if (!c[2])
        begin
          eo = eh;
        end
        else
        begin
          for (int i = 0; i < 4; i++)
          begin
            eh[i] = w;
            eo[i] = w;
          end
        end
      end
    endcase
  endtask
  task automatic byte_ack(input logic [7:0] b, input logic exp);
    u_i2c_master_model.send_byte(b, ack);
    chk_bit(ack, exp);
  endtask
  // whole write frame: start, address, control, one pair, stop
  task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic [7:0] hi, input logic [7:0] lo,
    input logic ok);
    u_i2c_master_model.start_c();
    byte_ack(a, ok);
    byte_ack(c, ok);
    byte_ack(hi, ok);
    byte_ack(lo, ok);
    u_i2c_master_model.stop_c();
    if (ok)
      upd(c, hi, lo);
    chk_all();
  endtask
  // repeated pairs under one control byte, and a lone high byte
  task automatic t_stream();
    u_i2c_master_model.start_c();
    byte_ack(8'h9c, 1'b1);
    byte_ack(8'h12, 1'b1);
    byte_ack(8'hab, 1'b1);
    repeat (6) @(negedge clk);
    chk_all();
    byte_ack(8'hc0, 1'b1);
    repeat (6) @(negedge clk);
    upd(8'h12, 8'hab, 8'hc0);
    chk_word(output_words[1], 12'h2af);
    byte_ack(8'h55, 1'b1);
    byte_ack(8'h40, 1'b1);
    repeat (6) @(negedge clk);
    upd(8'h12, 8'h55, 8'h40);
    chk_all();
    byte_ack(8'hff, 1'b1);
    u_i2c_master_model.stop_c();
    chk_all();
    $display("test stream done");
  endtask
  // every load mode, power-down words and the broadcast address
  task automatic t_modes();
    xfer(8'h9c, 8'h04, 8'h3c, 8'h80, 1'b1);
    xfer(8'h9c, 8'h26, 8'h81, 8'h40, 1'b1);
    xfer(8'h9c, 8'h13, 8'h80, 8'h00, 1'b1);
    xfer(8'h9c, 8'h00, 8'h77, 8'hc0, 1'b1);
    xfer(8'h90, 8'h30, 8'h00, 8'h00, 1'b1);
    xfer(8'h90, 8'h34, 8'hc3, 8'hc0, 1'b1);
    xfer(8'h90, 8'h35, 8'h40, 8'h00, 1'b1);
    $display("test modes done");
  endtask
  // straps moved after power-up, foreign address, reads refused
  task automatic t_refuse();
    addr_pin_hi = 1'b0;
    xfer(8'h98, 8'h12, 8'h11, 8'h11, 1'b0);
    xfer(8'h9d, 8'h12, 8'h11, 8'h11, 1'b0);
    xfer(8'h91, 8'h12, 8'h11, 8'h11, 1'b0);
    xfer(8'h9c, 8'h1e, 8'h5a, 8'h80, 1'b1);
    $display("test refuse done");
  endtask
  // master code, restart at high speed, stop back to normal
  task automatic t_hs();
    u_i2c_master_model.start_c();
    byte_ack(8'h0a, 1'b0);
    chk_bit(hs_mode, 1'b1);
    u_i2c_master_model.start_c();
    byte_ack(8'h9c, 1'b1);
    chk_bit(hs_mode, 1'b1);
    u_i2c_master_model.stop_c();
    repeat (4) @(negedge clk);
    chk_bit(hs_mode, 1'b0);
    chk_bit(sda_oe_n, 1'b1);
    $display("test hs done");
  endtask
  // hang guard, several times the expected run
  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  // reset for 6 cycles, at power-up and again in mid-run; every word must clear
  task automatic t_reset();
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    eo = '0;
    eh = '0;
    repeat (10) @(negedge clk);
    chk_bit(sda_oe_n, 1'b1);
    chk_bit(sda_out, 1'b0);
    chk_bit(hs_mode, 1'b0);
    chk_all();
    $display("test reset done");
  endtask
  initial
  begin
    t_reset();
    t_stream();
    t_modes();
    t_reset();
    t_refuse();
    t_hs();
    print_verdict();
  end
endmodule // quad_dac_i2c_write_decoder_tb_top
